// ===== dv/mma_monitor_sva.sv
// assertion checker on the motor monitor ports
`timescale 1ns/1ns
module mma_monitor_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic wb_stb,
  input wire logic wb_cyc,
  input wire logic wb_ack,
  input wire logic [31:0] wb_dat_r,
  input wire logic start_pulse,
  input wire logic ext_block_wr,
  input wire logic [7:0] func_ind_raw,
  input wire logic [7:0] func_evt_raw,
  input wire logic [7:0] func_ind,
  input wire logic [7:0] func_evt,
  input wire logic [7:0] func_timer_clr,
  input wire logic [7:0] block_flags,
  input wire logic breaker_failure,
  input wire logic welded_contactor,
  input wire logic learn_store,
  input wire logic [5:0] alarm_events,
  input wire logic block_event,
  input wire logic [7:0] block_event_state
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ****************
  // bus handshake
  // ****************
  sequence s_take;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence s_answer;
    wb_ack ##1 !wb_ack;
  endsequence
  a_ack_next: assert property (s_take |=> s_answer)
    else $error("bus answer not one cycle after request");
  a_dat_idle: assert property (!wb_ack |-> wb_dat_r == 32'h0)
    else $error("read data outside ack");
  // ****************
  // blocking and alarms
  // ****************
  a_ind_gated: assert property (
    func_ind == ($past(func_ind_raw) & ~$past(block_flags)))
    else $error("indication passed while blocked");
  a_evt_gated: assert property (
    func_evt == ($past(func_evt_raw) & ~$past(block_flags)))
    else $error("event passed while blocked");
  a_timer_held: assert property (func_timer_clr == block_flags)
    else $error("timers not held on blocked function");
  a_flag_cause: assert property (
    $changed(block_flags) |-> $past(ext_block_wr) || wb_ack)
    else $error("block flags changed without command");
  a_blk_state: assert property (
    block_event |-> block_event_state == block_flags)
    else $error("block event state wrong");
  a_fail_kind: assert property (
    !(breaker_failure && welded_contactor))
    else $error("both starter failure kinds reported");
  a_evt_once: assert property (
    |alarm_events |=> (alarm_events & $past(alarm_events)) == 6'h00)
    else $error("alarm event longer than one cycle");
  a_learn_cause: assert property (
    learn_store |-> $past(start_pulse) || $past(start_pulse, 2))
    else $error("learned store without start");
endmodule

bind mma_monitor mma_monitor_sva u_sva (
  .clk, .rst, .wb_stb, .wb_cyc, .wb_ack, .wb_dat_r, .start_pulse,
  .ext_block_wr, .func_ind_raw, .func_evt_raw, .func_ind, .func_evt,
  .func_timer_clr, .block_flags, .breaker_failure, .welded_contactor,
  .learn_store, .alarm_events, .block_event, .block_event_state
);

// ===== dv/mma_partner.sv
// model of starter contacts and measured motor current
`timescale 1ns/1ns
module mma_partner #(
  parameter int DLY = 10
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic trip_pulse,
  input wire logic start_pulse,
  input wire logic weld,
  input wire logic [15:0] lvl,
  output logic starter_status,
  output logic [15:0] current_mag
);
  logic run_q;
  int cnt;
  // current flows only while the contacts are closed
  assign current_mag = run_q ? lvl : 16'h0000;
  assign starter_status = run_q;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      run_q <= 1'b1;
      cnt <= 0;
    end else begin
      if (trip_pulse) begin
        cnt <= DLY;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
      // welded contacts never open, so status and current stay
      if (cnt == 1 && !weld) begin
        run_q <= 1'b0;
      end
      if (start_pulse) begin
        run_q <= 1'b1;
      end
    end
  end
endmodule

// ===== dv/tb.sv
// self-checking bench of the motor monitor block
`timescale 1ns/1ns
module tb;
  logic clk, rst, wb_we, wb_stb, wb_cyc, wb_ack, weld;
  logic trip_pulse, start_pulse, sample_tick, self_test_fail, ext_block_wr;
  logic [7:0] wb_adr, ext_block_mask, ext_block_val, func_ind_raw, m;
  logic [7:0] func_evt_raw, func_ind, func_evt, func_timer_clr, block_flags;
  logic [7:0] block_event_state, bst;
  logic [31:0] wb_dat_w, wb_dat_r, q;
  logic [3:0] wb_sel;
  logic [15:0] lvl, current_mag, kva_val;
  logic signed [16:0] kw_val, kvar_val;
  logic [5:0] alarm_events;
  logic starter_status, alarm_relay, auxiliary_output_one;
  logic auxiliary_output_two, breaker_failure, welded_contactor;
  logic learn_store, block_event;
  int n_errors, n_checks, nb, nl;
  int ne[6];
  // short starter step keeps the delay check fast
  mma_monitor #(.SF_STEP_CYC(5)) dut (
    .clk, .rst, .wb_adr, .wb_dat_w, .wb_sel, .wb_we, .wb_stb, .wb_cyc,
    .wb_dat_r, .wb_ack, .trip_pulse, .start_pulse, .starter_status,
    .current_mag, .kw_val, .kvar_val, .kva_val, .sample_tick,
    .self_test_fail, .ext_block_wr, .ext_block_mask, .ext_block_val,
    .func_ind_raw, .func_evt_raw, .func_ind, .func_evt, .func_timer_clr,
    .block_flags, .alarm_relay, .auxiliary_output_one,
    .auxiliary_output_two, .breaker_failure, .welded_contactor,
    .learn_store, .alarm_events, .block_event, .block_event_state
  );
  mma_partner far (.clk, .rst, .trip_pulse, .start_pulse, .weld, .lvl,
    .starter_status, .current_mag);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ****************
  // pulse monitor
  // ****************
  always @(posedge clk) begin
    if (block_event === 1'b1) begin
      nb++;
      bst = block_event_state;
    end
    if (learn_store === 1'b1) nl++;
    for (int i = 0; i < 6; i++) if (alarm_events[i] === 1'b1) ne[i]++;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic [31:0] d,
      input logic w);
    int t;
    t = 0;
    @(posedge clk);
    wb_adr <= a;
    wb_dat_w <= d;
    wb_we <= w;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (wb_ack !== 1'b1 && t < 50);
    chk(32'(wb_ack), 32'h1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, d, 1'b1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(a, 32'h0, 1'b0);
    chk(q, e);
  endtask
  task automatic pulse(input int k);
    @(posedge clk);
    case (k)
      0: trip_pulse <= 1'b1;
      1: start_pulse <= 1'b1;
      default: sample_tick <= 1'b1;
    endcase
    @(posedge clk);
    {trip_pulse, start_pulse, sample_tick} <= 3'b000;
    repeat (2) @(posedge clk);
  endtask
  task automatic minute;
    repeat (12) pulse(2);
    repeat (4) @(posedge clk);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    rdc(8'h00, 32'h000A1108);
    rdc(8'h04, 32'h00000019);
    rdc(8'h08, 32'h0000000A);
    rdc(8'h20, 32'h0000020F);
    rdc(8'h30, 32'h00000064);
    wr(8'hFC, 32'hFFFFFFFF);
    rdc(8'hFC, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_learn;
    wr(8'h00, 32'h00060000);
    repeat (2) pulse(1);
    repeat (3) @(posedge clk);
    chk(32'(nl), 32'h0);
    pulse(1);
    repeat (3) @(posedge clk);
    chk(32'(nl), 32'h1);
    $display("test learn done");
  endtask
  task automatic t_trip;
    wr(8'h00, 32'h00000026);
    wr(8'h0C, 32'h0);
    wr(8'h04, 32'h00000002);
    pulse(0);
    repeat (4) @(posedge clk);
    chk(32'(alarm_relay), 32'h0);
    pulse(0);
    repeat (4) @(posedge clk);
    chk(32'(alarm_relay), 32'h1);
    chk(32'(ne[0]), 32'h1);
    rdc(8'h0C, 32'h00000002);
    wr(8'h0C, 32'h0);
    repeat (4) @(posedge clk);
    chk(32'(alarm_relay), 32'h0);
    wr(8'h00, 32'h00000025);
    wr(8'h04, 32'h00000001);
    pulse(0);
    repeat (4) @(posedge clk);
    chk(32'(alarm_relay), 32'h1);
    wr(8'h04, 32'h00000005);
    repeat (4) @(posedge clk);
    chk(32'(alarm_relay), 32'h1);
    wr(8'h18, 32'h00000001);
    repeat (4) @(posedge clk);
    chk(32'(alarm_relay), 32'h0);
    wr(8'h04, 32'h00000001);
    wr(8'h0C, 32'h0);
    repeat (2) @(posedge clk);
    chk(32'(alarm_relay), 32'h0);
    $display("test trip counter done");
  endtask
  task automatic t_starter;
    wr(8'h00, 32'h00000480);
    pulse(1);
    pulse(0);
    repeat (80) @(posedge clk);
    chk(32'(breaker_failure), 32'h0);
    pulse(1);
    weld <= 1'b1;
    pulse(0);
    repeat (40) @(posedge clk);
    chk(32'(breaker_failure), 32'h0);
    repeat (30) @(posedge clk);
    chk(32'(breaker_failure), 32'h1);
    chk(32'(auxiliary_output_two), 32'h1);
    wr(8'h00, 32'h00001480);
    repeat (2) @(posedge clk);
    chk(32'({breaker_failure, welded_contactor}), 32'h1);
    wr(8'h00, 32'h0);
    weld <= 1'b0;
    $display("test starter done");
  endtask
  task automatic t_demand;
    wr(8'h20, 32'h00001505);
    wr(8'h30, 32'h00000096);
    pulse(1);
    repeat (5) minute();
    rdc(8'h40, 32'h00000064);
    chk(32'(auxiliary_output_one), 32'h0);
    lvl <= 16'h0190;
    minute();
    rdc(8'h40, 32'h000000A0);
    chk(32'(auxiliary_output_one), 32'h1);
    chk(32'(ne[2]), 32'h1);
    rdc(8'h44, 32'h0);
    rdc(8'h48, 32'h0000001E);
    rdc(8'h4C, 32'h000000C8);
    wr(8'h20, 32'h0);
    $display("test demand done");
  endtask
  task automatic t_block;
    wr(8'h00, 32'h00010000);
    @(posedge clk);
    ext_block_wr <= 1'b1;
    ext_block_mask <= 8'h81;
    ext_block_val <= 8'h81;
    @(posedge clk);
    ext_block_wr <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(func_ind), 32'h7E);
    chk(32'(func_evt), 32'h7E);
    chk(32'(func_timer_clr), 32'h81);
    chk(32'({nb, bst}), 32'h181);
    for (int i = 0; i < 8; i++) begin
      m = 8'h01 << i;
      wr(8'h10, 32'(m));
      repeat (2) @(posedge clk);
      chk(32'(func_ind), 32'(m ^ 8'hFF));
    end
    wr(8'h10, 32'h0);
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h0000000F);
    repeat (2) @(posedge clk);
    chk(32'(nb), 32'hA);
    wr(8'h10, 32'h0);
    $display("test block done");
  endtask
  task automatic t_self;
    wr(8'h00, 32'h0000C000);
    self_test_fail <= 1'b1;
    repeat (4) @(posedge clk);
    chk(32'({alarm_relay, auxiliary_output_one, auxiliary_output_two}),
      32'h3);
    self_test_fail <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'(auxiliary_output_one), 32'h0);
    $display("test self test done");
  endtask
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    {rst, wb_we, wb_stb, wb_cyc, weld, trip_pulse, start_pulse} = 7'h40;
    {sample_tick, self_test_fail, ext_block_wr} = 3'h0;
    {wb_adr, ext_block_mask, ext_block_val, func_evt_raw} = 32'h0;
    func_ind_raw = 8'h0;
    wb_dat_w = 32'h0;
    wb_sel = 4'hF;
    lvl = 16'h0064;
    kva_val = 16'h00C8;
    kw_val = -17'sd50;
    kvar_val = 17'sd30;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_learn();
    t_trip();
    t_starter();
    t_demand();
    func_ind_raw <= 8'hFF;
    func_evt_raw <= 8'hFF;
    t_block();
    t_self();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    report_and_stop();
  end
endmodule

// ===== inc/mma_pkg.sv
// shared constants and types of the motor monitor and alarm block
package mma_pkg;
  // ****************************************
  // alarm modes
  // ****************************************
  typedef enum logic [1:0] {
    MMA_OFF,
    MMA_LATCHED,
    MMA_UNLATCHED
  } mma_mode_t;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [7:0] MMA_CTRL_ADR = 8'h00;
  localparam logic [7:0] MMA_TC_PICK_ADR = 8'h04;
  localparam logic [7:0] MMA_SF_DLY_ADR = 8'h08;
  localparam logic [7:0] MMA_TC_CNT_ADR = 8'h0C;
  localparam logic [7:0] MMA_BLOCK_ADR = 8'h10;
  localparam logic [7:0] MMA_STATUS_ADR = 8'h14;
  localparam logic [7:0] MMA_RESET_ADR = 8'h18;
  localparam logic [7:0] MMA_DCFG_ADR = 8'h20;
  localparam logic [7:0] MMA_DLIM_ADR = 8'h30;
  localparam logic [7:0] MMA_DVAL_ADR = 8'h40;

  // ****************************************
  // fields of the control register
  // ****************************************
  localparam int MMA_TC_MODE_POS = 0;
  localparam int MMA_TC_RLY_POS = 2;
  localparam int MMA_TC_EVT_POS = 5;
  localparam int MMA_SF_MODE_POS = 6;
  localparam int MMA_SF_RLY_POS = 8;
  localparam int MMA_SF_EVT_POS = 11;
  localparam int MMA_SF_TYPE_POS = 12;
  localparam int MMA_SVC_RLY_POS = 13;
  localparam int MMA_LOG_BLK_POS = 16;
  localparam int MMA_LEARN_POS = 17;
  // fields of a demand configuration register
  localparam int MMA_DPER_POS = 0;
  localparam int MMA_DMODE_POS = 7;
  localparam int MMA_DRLY_POS = 9;
  localparam int MMA_DEVT_POS = 12;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [19:0] MMA_CTRL_RST = 20'hA1108;
  localparam logic [15:0] MMA_TC_PICK_RST = 16'h0019;
  localparam logic [6:0] MMA_SF_DLY_RST = 7'h0A;
  localparam logic [12:0] MMA_DCFG_RST = 13'h020F;
  localparam logic [15:0] MMA_DLIM_RST = 16'h0064;

  // ****************************************
  // ranges and timing
  // ****************************************
  localparam logic [6:0] MMA_DPER_MIN = 7'h05;
  localparam logic [6:0] MMA_DPER_MAX = 7'h5A;
  localparam logic [2:0] MMA_LEARN_MAX = 3'h5;
  localparam logic [3:0] MMA_SMP_PER_MIN = 4'hC;
  localparam int MMA_CLK_NS = 4;
  localparam int MMA_SF_STEP_NS = 10000000;
  localparam int MMA_SF_STEP_CYC = MMA_SF_STEP_NS / MMA_CLK_NS;
endpackage

// ===== verilog/mma_alarm.sv
// one alarm element: mode handling, latch and event pulse
`timescale 1ns/1ns
module mma_alarm (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic events_en,
  input wire logic cond,
  input wire logic reset_cmd,
  input wire logic force_clr,
  output logic active,
  output logic evt
);
  typedef struct packed {
    logic act;
    logic evt;
  } mma_alarm_st_t;

  mma_alarm_st_t q, d;

  always_comb begin
    d = q;
    case (mma_pkg::mma_mode_t'(mode))
      mma_pkg::MMA_LATCHED: begin
        if (cond) begin
          d.act = 1'b1;
        end else if (reset_cmd || force_clr) begin
          d.act = 1'b0;
        end
      end
      mma_pkg::MMA_UNLATCHED: d.act = cond;
      default: d.act = 1'b0;
    endcase
    d.evt = events_en && d.act && !q.act;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign active = q.act;
  assign evt = q.evt;
endmodule

// ===== verilog/mma_demand.sv
// rolling demand of one quantity over a per-minute fifo
`timescale 1ns/1ns
module mma_demand (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic [15:0] value,
  input wire logic [6:0] period,
  output logic [15:0] demand
);
  localparam int DEPTH = 90;

  typedef struct packed {
    logic [6:0] wp;
    logic [6:0] cnt;
    logic [6:0] per;
    logic [22:0] sum;
    logic go;
    logic [15:0] dem;
  } mma_demand_st_t;

  mma_demand_st_t q, d;
  logic [15:0] mem [DEPTH];
  logic [6:0] per_c;
  logic [6:0] old_ix;

  function automatic logic [6:0] ring_sub(input logic [6:0] a,
                                          input logic [6:0] b);
    ring_sub = (a >= b) ? 7'(a - b) : 7'(a + 7'(DEPTH) - b);
  endfunction

  always_comb begin
    d = q;
    d.go = 1'b0;
    per_c = period;
    if (period < mma_pkg::MMA_DPER_MIN) begin
      per_c = mma_pkg::MMA_DPER_MIN;
    end else if (period > mma_pkg::MMA_DPER_MAX) begin
      per_c = mma_pkg::MMA_DPER_MAX;
    end
    old_ix = ring_sub(q.wp, q.per);
    // new period restarts the window; mixed windows would skew the mean
    if (per_c != q.per) begin
      d.per = per_c;
      d.cnt = '0;
      d.sum = '0;
    end else if (push) begin
      if (q.cnt == q.per) begin
        d.sum = 23'(q.sum + 23'(value) - 23'(mem[old_ix]));
      end else begin
        d.sum = 23'(q.sum + 23'(value));
        d.cnt = 7'(q.cnt + 7'h01);
      end
      d.wp = (q.wp == 7'(DEPTH - 1)) ? 7'h00 : 7'(q.wp + 7'h01);
      d.go = 1'b1;
    end
    if (q.go && q.cnt != 7'h00) begin
      d.dem = 16'(q.sum / 23'(q.cnt));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk) begin
    if (push && per_c == q.per) begin
      mem[q.wp] <= value;
    end
  end

  assign demand = q.dem;
endmodule

// ===== verilog/mma_monitor.sv
// motor monitoring, demand, alarms and block functions with wishbone regs
//
// Contract
// - trip count reaching pickup raises alarm
// - clears on count clear or raised pickup; latched mode clears only on count clear or reset command
// - alarm modes off, latched, unlatched
// - each alarm drives chosen output relays
// - after trip, check status change, zero current
// - starter failure delay 10 to 1000 ms; code takes 1 to 127 steps of 10 ms, up to 1270 ms
// - breaker failure or welded contactor by type
// - learned record stored after set starts
// - per-minute average from five-second samples
// - fifo depth equals demand period minutes
// - demand is mean of buffer contents
// - only positive kW and kvar accumulate
// - demand alarm when value reaches limit
// - service relays follow self-test failure
// - eight individual protection block flags
// - block flag settable from several sources
// - blocked function gives no indication, event
// - blocking resets function timers to zero
// - log event on each block change
//
// Chosen here: register access over Wishbone and the address map.
`timescale 1ns/1ns
module mma_monitor #(
  parameter int SF_STEP_CYC = mma_pkg::MMA_SF_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr,
  input wire logic [31:0] wb_dat_w,
  input wire logic [3:0] wb_sel,
  input wire logic wb_we,
  input wire logic wb_stb,
  input wire logic wb_cyc,
  output logic [31:0] wb_dat_r,
  output logic wb_ack,
  input wire logic trip_pulse,
  input wire logic start_pulse,
  input wire logic starter_status,
  input wire logic [15:0] current_mag,
  input wire logic signed [16:0] kw_val,
  input wire logic signed [16:0] kvar_val,
  input wire logic [15:0] kva_val,
  input wire logic sample_tick,
  input wire logic self_test_fail,
  input wire logic ext_block_wr,
  input wire logic [7:0] ext_block_mask,
  input wire logic [7:0] ext_block_val,
  input wire logic [7:0] func_ind_raw,
  input wire logic [7:0] func_evt_raw,
  output logic [7:0] func_ind,
  output logic [7:0] func_evt,
  output logic [7:0] func_timer_clr,
  output logic [7:0] block_flags,
  output logic alarm_relay,
  output logic auxiliary_output_one,
  output logic auxiliary_output_two,
  output logic breaker_failure,
  output logic welded_contactor,
  output logic learn_store,
  output logic [5:0] alarm_events,
  output logic block_event,
  output logic [7:0] block_event_state
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [19:0] ctrl;
    logic [15:0] tc_pick;
    logic [6:0] sf_dly;
    logic [15:0] tc_cnt;
    logic [7:0] blk;
    logic [3:0][12:0] dcfg;
    logic [3:0][15:0] dlim;
    logic rst_cmd;
    logic tc_clr;
    logic st_s1;
    logic st_s2;
    logic sf_arm;
    logic sf_stat0;
    logic [6:0] sf_steps;
    logic [21:0] sf_cyc;
    logic sf_cond;
    logic [3:0][19:0] acc;
    logic [3:0] smp;
    logic [3:0][15:0] avg;
    logic push;
    logic [2:0] learn_cnt;
    logic learn_st;
    logic evt_blk;
    logic [7:0] evt_blk_st;
    logic [7:0] ind;
    logic [7:0] fevt;
    logic [2:0] rly;
  } mma_top_st_t;

  mma_top_st_t q, d;
  logic [5:0] act;
  logic [5:0] cond;
  logic [3:0][15:0] dem;
  logic [3:0][15:0] smp_val;
  logic hit;
  logic [31:0] rd;
  logic [15:0] tc_next;
  logic [2:0] learn_n;
  logic [7:0] blk_n;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  function automatic logic [15:0] pos16(input logic signed [16:0] v);
    pos16 = v[16] ? 16'h0000 : v[15:0];
  endfunction

  function automatic logic [2:0] relay_or(input logic [5:0] a,
                                          input logic [3:0][12:0] c,
                                          input logic [19:0] k);
    relay_or = ({3{a[0]}} & k[mma_pkg::MMA_TC_RLY_POS +: 3])
      | ({3{a[1]}} & k[mma_pkg::MMA_SF_RLY_POS +: 3]);
    for (int i = 0; i < 4; i++) begin
      relay_or = relay_or | ({3{a[i+2]}} & c[i][mma_pkg::MMA_DRLY_POS +: 3]);
    end
  endfunction

  assign smp_val[0] = current_mag;
  assign smp_val[1] = pos16(kw_val);
  assign smp_val[2] = pos16(kvar_val);
  assign smp_val[3] = kva_val;

  assign hit = wb_cyc && wb_stb && !q.ack;

  // ****************************************
  // register reads
  // ****************************************
  always_comb begin
    rd = 32'h0000_0000;
    case (wb_adr)
      mma_pkg::MMA_CTRL_ADR: rd = 32'(q.ctrl);
      mma_pkg::MMA_TC_PICK_ADR: rd = 32'(q.tc_pick);
      mma_pkg::MMA_SF_DLY_ADR: rd = 32'(q.sf_dly);
      mma_pkg::MMA_TC_CNT_ADR: rd = 32'(q.tc_cnt);
      mma_pkg::MMA_BLOCK_ADR: rd = 32'(q.blk);
      mma_pkg::MMA_STATUS_ADR: rd = {22'h000000, q.sf_arm, q.rly, act};
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (wb_adr == 8'(mma_pkg::MMA_DCFG_ADR + 8'(4 * i))) begin
            rd = 32'(q.dcfg[i]);
          end
          if (wb_adr == 8'(mma_pkg::MMA_DLIM_ADR + 8'(4 * i))) begin
            rd = 32'(q.dlim[i]);
          end
          if (wb_adr == 8'(mma_pkg::MMA_DVAL_ADR + 8'(4 * i))) begin
            rd = 32'(dem[i]);
          end
        end
      end
    endcase
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.ack = hit;
    d.rdat = hit ? rd : 32'h0000_0000;
    d.rst_cmd = 1'b0;
    d.tc_clr = 1'b0;
    d.push = 1'b0;
    d.learn_st = 1'b0;
    d.evt_blk = 1'b0;
    blk_n = q.blk;
    // register writes, byte lanes honoured
    if (hit && wb_we) begin
      case (wb_adr)
        mma_pkg::MMA_CTRL_ADR: d.ctrl = 20'(merge(32'(q.ctrl), wb_dat_w,
                                                  wb_sel));
        mma_pkg::MMA_TC_PICK_ADR: d.tc_pick = 16'(merge(32'(q.tc_pick),
                                                        wb_dat_w, wb_sel));
        mma_pkg::MMA_SF_DLY_ADR: d.sf_dly = 7'(merge(32'(q.sf_dly),
                                                     wb_dat_w, wb_sel));
        mma_pkg::MMA_TC_CNT_ADR: d.tc_clr = 1'b1;
        mma_pkg::MMA_BLOCK_ADR: blk_n = 8'(merge(32'(q.blk), wb_dat_w,
                                                 wb_sel));
        mma_pkg::MMA_RESET_ADR: d.rst_cmd = wb_dat_w[0];
        default: begin
          for (int i = 0; i < 4; i++) begin
            if (wb_adr == 8'(mma_pkg::MMA_DCFG_ADR + 8'(4 * i))) begin
              d.dcfg[i] = 13'(merge(32'(q.dcfg[i]), wb_dat_w, wb_sel));
            end
            if (wb_adr == 8'(mma_pkg::MMA_DLIM_ADR + 8'(4 * i))) begin
              d.dlim[i] = 16'(merge(32'(q.dlim[i]), wb_dat_w, wb_sel));
            end
          end
        end
      endcase
    end

    if (ext_block_wr) begin
      blk_n = (blk_n & ~ext_block_mask) | (ext_block_val & ext_block_mask);
    end
    d.blk = blk_n;
    if (blk_n != q.blk && q.ctrl[mma_pkg::MMA_LOG_BLK_POS]) begin
      d.evt_blk = 1'b1;
      d.evt_blk_st = blk_n;
    end
    d.ind = func_ind_raw & ~q.blk;
    d.fevt = func_evt_raw & ~q.blk;

    // saturating trip count; a trip beats a clear
    tc_next = q.tc_clr ? 16'h0000 : q.tc_cnt;
    if (trip_pulse && tc_next != 16'hFFFF) begin
      tc_next = 16'(tc_next + 16'h0001);
    end
    d.tc_cnt = tc_next;

    // starter status pin synchroniser
    d.st_s1 = starter_status;
    d.st_s2 = q.st_s1;
    if (trip_pulse && q.ctrl[mma_pkg::MMA_SF_MODE_POS +: 2] != 2'h0) begin
      d.sf_arm = 1'b1;
      d.sf_stat0 = q.st_s2;
      d.sf_steps = (q.sf_dly == 7'h00) ? 7'h01 : q.sf_dly;
      d.sf_cyc = '0;
      d.sf_cond = 1'b0;
    end else if (q.sf_arm) begin
      if (q.sf_cyc == 22'(SF_STEP_CYC - 1)) begin
        d.sf_cyc = '0;
        d.sf_steps = 7'(q.sf_steps - 7'h01);
        if (q.sf_steps <= 7'h01) begin
          d.sf_arm = 1'b0;
          d.sf_cond = (q.st_s2 == q.sf_stat0) || (current_mag != 16'h0000);
        end
      end else begin
        d.sf_cyc = 22'(q.sf_cyc + 22'h000001);
      end
    end else if (q.st_s2 != q.sf_stat0 && current_mag == 16'h0000) begin
      d.sf_cond = 1'b0;
    end

    if (sample_tick) begin
      for (int i = 0; i < 4; i++) begin
        d.acc[i] = 20'(q.acc[i] + 20'(smp_val[i]));
      end
      d.smp = 4'(q.smp + 4'h1);
      if (q.smp == 4'(mma_pkg::MMA_SMP_PER_MIN - 4'h1)) begin
        for (int i = 0; i < 4; i++) begin
          d.avg[i] = 16'(d.acc[i] / 20'(mma_pkg::MMA_SMP_PER_MIN));
          d.acc[i] = '0;
        end
        d.smp = '0;
        d.push = 1'b1;
      end
    end

    learn_n = q.ctrl[mma_pkg::MMA_LEARN_POS +: 3];
    if (learn_n == 3'h0) begin
      learn_n = 3'h1;
    end else if (learn_n > mma_pkg::MMA_LEARN_MAX) begin
      learn_n = mma_pkg::MMA_LEARN_MAX;
    end
    if (start_pulse) begin
      d.learn_cnt = 3'(q.learn_cnt + 3'h1);
      if (d.learn_cnt >= learn_n) begin
        d.learn_cnt = 3'h0;
        d.learn_st = 1'b1;
      end
    end

    d.rly = relay_or(act, q.dcfg, q.ctrl);
    if (self_test_fail) begin
      d.rly = d.rly | q.ctrl[mma_pkg::MMA_SVC_RLY_POS +: 3];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.ctrl <= mma_pkg::MMA_CTRL_RST;
      q.tc_pick <= mma_pkg::MMA_TC_PICK_RST;
      q.sf_dly <= mma_pkg::MMA_SF_DLY_RST;
      q.dcfg <= {4{mma_pkg::MMA_DCFG_RST}};
      q.dlim <= {4{mma_pkg::MMA_DLIM_RST}};
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // alarm elements and demand
  // ****************************************
  // count reaches pickup
  assign cond[0] = (q.tc_pick != 16'h0000) && (q.tc_cnt >= q.tc_pick)
    && !q.tc_clr;
  assign cond[1] = q.sf_cond;

  mma_alarm u_tc_alarm (
    .clk(clk),
    .rst(rst),
    .mode(q.ctrl[mma_pkg::MMA_TC_MODE_POS +: 2]),
    .events_en(q.ctrl[mma_pkg::MMA_TC_EVT_POS]),
    .cond(cond[0]),
    .reset_cmd(q.rst_cmd),
    .force_clr(q.tc_clr),
    .active(act[0]),
    .evt(alarm_events[0])
  );

  mma_alarm u_sf_alarm (
    .clk(clk),
    .rst(rst),
    .mode(q.ctrl[mma_pkg::MMA_SF_MODE_POS +: 2]),
    .events_en(q.ctrl[mma_pkg::MMA_SF_EVT_POS]),
    .cond(cond[1]),
    .reset_cmd(q.rst_cmd),
    .force_clr(1'b0),
    .active(act[1]),
    .evt(alarm_events[1])
  );

  for (genvar g = 0; g < 4; g++) begin : g_dem
    mma_demand u_dem (
      .clk(clk),
      .rst(rst),
      .push(q.push),
      .value(q.avg[g]),
      .period(q.dcfg[g][mma_pkg::MMA_DPER_POS +: 7]),
      .demand(dem[g])
    );
    assign cond[g+2] = dem[g] >= q.dlim[g];
    mma_alarm u_dem_alarm (
      .clk(clk),
      .rst(rst),
      .mode(q.dcfg[g][mma_pkg::MMA_DMODE_POS +: 2]),
      .events_en(q.dcfg[g][mma_pkg::MMA_DEVT_POS]),
      .cond(cond[g+2]),
      .reset_cmd(q.rst_cmd),
      .force_clr(1'b0),
      .active(act[g+2]),
      .evt(alarm_events[g+2])
    );
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_ack = q.ack;
  assign wb_dat_r = q.rdat;
  assign func_ind = q.ind;
  assign func_evt = q.fevt;
  assign func_timer_clr = q.blk;
  assign block_flags = q.blk;
  assign alarm_relay = q.rly[0];
  assign auxiliary_output_one = q.rly[1];
  assign auxiliary_output_two = q.rly[2];
  assign breaker_failure = act[1] && !q.ctrl[mma_pkg::MMA_SF_TYPE_POS];
  assign welded_contactor = act[1] && q.ctrl[mma_pkg::MMA_SF_TYPE_POS];
  assign learn_store = q.learn_st;
  assign block_event = q.evt_blk;
  assign block_event_state = q.evt_blk_st;
endmodule
